// File: bench/redriver_regs_asserts.sv
// Purpose: Port-level checks of the redriver register bank.
// Assumes: One clock domain with synchronous active-high reset.
// Notes:   Bound to the bank at the foot of this file.
`timescale 1ns/1ps
module redriver_regs_checker (
  input wire logic                        core_clk,
  input wire logic                        srst,
  input wire logic                        scl_in,
  input wire logic                        sda_o,
  input wire logic                        sda_oe_n,
  input redriver_regs_pkg::aeq_report_type aeq_rpt,
  input redriver_regs_pkg::aeq_config_type aeq_cfg,
  input wire logic [6:0][3:0]             eq_select,
  input wire logic [1:0][3:0]             long_eq_select,
  input wire logic [6:0][3:0]             eq_applied,
  input wire logic [1:0]                  beacon_transmit_swing,
  input wire logic [1:0]                  display_path_swing,
  input wire logic [1:0]                  downstream_transmit_swing,
  input wire logic [1:0]                  upstream_transmit_swing,
  input wire logic [1:0]                  upstream_limited_swing
);
  logic [7:0] low_run_q;
  logic [7:0] low_run_d;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  // Counts how long the bank has held the data line low.
  always_comb begin
    low_run_d = sda_oe_n ? 8'h00 : low_run_q + {7'h00, low_run_q != 8'hff};
  end
  always_ff @(posedge core_clk) begin
    low_run_q <= srst ? 8'h00 : low_run_d;
  end

  sequence fast_mode;
    aeq_cfg.adaptive_equalizer_enable && !aeq_cfg.adaptive_equalizer_variant
      && !aeq_cfg.override_active;
  endsequence
  sequence fixed_mode;
    !aeq_cfg.adaptive_equalizer_enable && !aeq_cfg.forced_search_enable
      && !aeq_cfg.override_active;
  endsequence

  a_reset_levels:
    assert property ($fell(srst) |-> sda_oe_n && beacon_transmit_swing == 2'h2
      && {display_path_swing, downstream_transmit_swing} == 4'hf
      && {upstream_transmit_swing, upstream_limited_swing} == 4'hf)
    else $error("swing levels wrong after reset");
  a_fast_long:
    assert property (fast_mode ##0 aeq_rpt.long_detected |=>
      eq_applied[1:0] == $past(long_eq_select))
    else $error("long preset not applied");
  a_fast_short:
    assert property (fast_mode ##0 !aeq_rpt.long_detected |=>
      eq_applied[1:0] == $past(eq_select[1:0]))
    else $error("short preset not applied");
  a_fixed_setting:
    assert property (fixed_mode |=> eq_applied == $past(eq_select))
    else $error("fixed setting not applied");
  a_other_inputs:
    assert property (1'b1 |=> eq_applied[6:2] == $past(eq_select[6:2]))
    else $error("setting of a plain input not applied");
  a_limited_hold:
    assert property (!$past(aeq_cfg.upstream_limited_driver_enable)
      |-> $stable(upstream_limited_swing))
    else $error("limited swing moved while disabled");
  a_upstream_hold:
    assert property ($past(aeq_cfg.upstream_limited_driver_enable)
      |-> $stable(upstream_transmit_swing))
    else $error("upstream level moved while limited");
  a_data_open_drain:
    assert property (sda_o == 1'b0)
    else $error("data pin value not low");
  a_drive_clock_low:
    assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2))
    else $error("data line moved while serial clock high");
  a_drive_bounded:
    assert property (low_run_q <= 8'hc8)
    else $error("data line held low too long");
endmodule // redriver_regs_checker

bind redriver_link_status_and_swing_regs redriver_regs_checker u_checker (
  .core_clk(core_clk), .srst(srst), .scl_in(scl_in), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .aeq_rpt(aeq_rpt), .aeq_cfg(aeq_cfg),
  .eq_select(eq_select), .long_eq_select(long_eq_select),
  .eq_applied(eq_applied), .beacon_transmit_swing(beacon_transmit_swing),
  .display_path_swing(display_path_swing),
  .downstream_transmit_swing(downstream_transmit_swing),
  .upstream_transmit_swing(upstream_transmit_swing),
  .upstream_limited_swing(upstream_limited_swing)
);

// File: bench/serial_host_model.sv
// Purpose: Host side of the serial control port, driven by bench tasks.
// Assumes: Data line is open drain with a pull-up.
// Notes:   Clock phases last 8 core_clk cycles; lines move on falls.
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic core_clk,
  input  wire logic sda_oe_n,
  output logic      scl_in,
  output logic      sda_in
);
  logic host_low;

  // Either party may pull the data line low; otherwise it floats high.
  assign sda_in = ~host_low & sda_oe_n;

  initial begin
    scl_in = 1'b1;
    host_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic line_bit(input logic b, output logic r);
    hold(4);
    host_low = ~b;
    hold(4);
    scl_in = 1'b1;
    hold(8);
    r = sda_in;
    scl_in = 1'b0;
  endtask

  task automatic bus_start();
    hold(4);
    host_low = 1'b0;
    hold(4);
    scl_in = 1'b1;
    hold(8);
    host_low = 1'b1;
    hold(8);
    scl_in = 1'b0;
  endtask

  task automatic bus_stop();
    hold(4);
    host_low = 1'b1;
    hold(4);
    scl_in = 1'b1;
    hold(8);
    host_low = 1'b0;
    hold(8);
  endtask

  // The ninth slot is always released, so the device answers in it.
  task automatic xbyte(input logic [7:0] d, output logic [7:0] r,
                       output logic ack);
    for (int i = 7; i >= 0; i--) begin
      line_bit(d[i], r[i]);
    end
    line_bit(1'b1, ack);
  endtask
endmodule // serial_host_model

// File: bench/test_redriver_link_status_and_swing_regs.sv
// Purpose: Self-checking bench of the redriver register bank.
// Assumes: The host model reaches the bank over the serial port.
// Notes:   Expected values follow the register map and swing coding.
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("wrong value %s: expected %h, seen %h", what, exp, got); \
    end \
  end
module test_redriver_link_status_and_swing_regs;
  logic                              core_clk, srst, scl_in, sda_in;
  logic                              sda_o, sda_oe_n;
  redriver_regs_pkg::link_event_type link_evt;
  redriver_regs_pkg::aeq_report_type aeq_rpt;
  redriver_regs_pkg::aeq_config_type aeq_cfg;
  logic [6:0][3:0]                   eq_select, eq_applied;
  logic [1:0][3:0]                   long_eq_select;
  logic [1:0]                        beacon, display, downstr, upstr, limit;
  logic [9:0]                        levels;
  int                                n_errors, comparisons;

  assign levels = {beacon, display, downstr, upstr, limit};

  redriver_link_status_and_swing_regs DUT (
    .core_clk(core_clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .link_evt(link_evt),
    .aeq_rpt(aeq_rpt), .aeq_cfg(aeq_cfg), .eq_select(eq_select),
    .long_eq_select(long_eq_select), .eq_applied(eq_applied),
    .beacon_transmit_swing(beacon), .display_path_swing(display),
    .downstream_transmit_swing(downstr), .upstream_transmit_swing(upstr),
    .upstream_limited_swing(limit)
  );
  serial_host_model host (
    .core_clk(core_clk), .sda_oe_n(sda_oe_n), .scl_in(scl_in),
    .sda_in(sda_in)
  );

  always #20 core_clk = ~core_clk;

  task automatic access(input logic [7:0] ofs, input logic rd_n_wr,
                        input logic [7:0] d, output logic [7:0] r);
    logic [2:0] ack;
    logic       nk;
    host.bus_start();
    host.xbyte({redriver_regs_pkg::TARGET_ADDR, 1'b0}, r, ack[2]);
    host.xbyte(ofs, r, ack[1]);
    if (rd_n_wr) begin
      host.bus_start();
      host.xbyte({redriver_regs_pkg::TARGET_ADDR, 1'b1}, r, ack[0]);
      host.xbyte(8'hff, r, nk);
    end else begin
      host.xbyte(d, r, ack[0]);
    end
    host.bus_stop();
    `CHECK("ack", 3'h0, ack)
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] r;
    access(ofs, 1'b0, d, r);
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp,
                    input string what);
    logic [7:0] r;
    access(ofs, 1'b1, 8'h00, r);
    `CHECK(what, exp, r)
  endtask

  task automatic evt(input logic [2:0] p);
    @(negedge core_clk);
    link_evt[3:1] = p;
    @(negedge core_clk);
    link_evt[3:1] = 3'h0;
  endtask

  task automatic hits(input int n);
    repeat (n) begin
      @(negedge core_clk);
      aeq_rpt.hit = 1'b1;
      @(negedge core_clk);
      aeq_rpt.hit = 1'b0;
    end
  endtask

  task automatic pulse_reset();
    @(negedge core_clk);
    srst = 1'b1;
    repeat (5) @(negedge core_clk);
    srst = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #3_600_000;
    n_errors++;
    test_done();
  end

  initial begin
    logic [7:0] r;
    logic       nk;
    core_clk = 1'b0;
    srst = 1'b1;
    link_evt = '0;
    aeq_rpt = '0;
    aeq_cfg = '0;
    long_eq_select = {4'hd, 4'hc};
    for (int i = 0; i < 7; i++) begin
      eq_select[i] = 4'(i + 3);
    end
    n_errors = 0;
    comparisons = 0;
    pulse_reset();
    rd(8'h24, 8'h41, "link flags");
    rd(8'h32, 8'h40, "linearity");
    rd(8'h3b, 8'h00, "eq result");
    `CHECK("levels", 10'h2ff, levels)
    $display("test reset values done");
    wr(8'h24, 8'hff);
    wr(8'h3b, 8'hff);
    rd(8'h24, 8'h41, "flags after write");
    rd(8'h3b, 8'h00, "result after write");
    rd(8'h50, 8'h00, "unmapped");
    $display("test read-only done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h32, {4{c[1:0]}});
      rd(8'h32, {4{c[1:0]}}, "linearity");
      `CHECK("levels", {{4{~c[1:0]}}, 2'h3}, levels)
    end
    aeq_cfg.upstream_limited_driver_enable = 1'b1;
    wr(8'h32, 8'h01);
    `CHECK("limited levels", 10'h3f2, levels)
    aeq_cfg.upstream_limited_driver_enable = 1'b0;
    $display("test swing done");
    link_evt.compliance = 1'b1;
    rd(8'h24, 8'h49, "compliance");
    link_evt.compliance = 1'b0;
    for (int i = 0; i < 4; i++) begin
      evt(3'h4 >> (i % 3));
      rd(8'h24, 8'h40 | 8'h04 >> i % 3, "state");
    end
    $display("test link state done");
    aeq_cfg.adaptive_equalizer_enable = 1'b1;
    aeq_rpt.long_detected = 1'b1;
    rd(8'h24, 8'hc4, "long channel");
    rd(8'h3b, 8'h0c, "fast setting");
    `CHECK("long presets", 8'hdc, eq_applied[1:0])
    aeq_rpt.long_detected = 1'b0;
    rd(8'h24, 8'h44, "short channel");
    rd(8'h3b, 8'h03, "fast setting");
    `CHECK("short presets", 8'h43, eq_applied[1:0])
    aeq_cfg.adaptive_equalizer_enable = 1'b0;
    aeq_rpt.long_detected = 1'b1;
    rd(8'h24, 8'h44, "adaptive off");
    `CHECK("fixed settings", eq_select, eq_applied)
    aeq_rpt.long_detected = 1'b0;
    $display("test fast mode done");
    aeq_cfg.adaptive_equalizer_enable = 1'b1;
    aeq_cfg.adaptive_equalizer_variant = 1'b1;
    aeq_rpt.full_result = 4'ha;
    aeq_rpt.running = 1'b1;
    rd(8'h24, 8'h04, "search running");
    hits(8191);
    rd(8'h24, 8'h04, "hits below wrap");
    hits(1);
    rd(8'h24, 8'h24, "hit overflow");
    aeq_rpt.running = 1'b0;
    rd(8'h24, 8'h64, "search done");
    rd(8'h3b, 8'h0a, "full result");
    aeq_rpt.dac_expired = 1'b1;
    @(negedge core_clk);
    aeq_rpt.dac_expired = 1'b0;
    rd(8'h3b, 8'h1a, "settle timer");
    aeq_cfg.override_active = 1'b1;
    aeq_cfg.equalizer_override_value = 4'h5;
    rd(8'h3b, 8'h15, "override");
    $display("test full search done");
    host.bus_start();
    host.xbyte({redriver_regs_pkg::TARGET_ADDR ^ 7'h01, 1'b0}, r, nk);
    host.bus_stop();
    `CHECK("foreign address nack", 1'b1, nk)
    aeq_cfg = '0;
    pulse_reset();
    rd(8'h24, 8'h41, "flags after reset");
    rd(8'h32, 8'h40, "linearity after reset");
    `CHECK("levels after reset", 10'h2ff, levels)
    $display("test second reset done");
    test_done();
  end
endmodule // test_redriver_link_status_and_swing_regs

// File: common/redriver_regs_pkg.sv
// Purpose: Shared constants and carriers of the redriver status bank.
// Assumes: Eight-bit registers on an eight-bit register pointer.
// Notes:   Two-bit swing codes run from top level (0) to bottom (3).
package redriver_regs_pkg;

  localparam logic [7:0] LINK_FLAGS_OFS  = 8'h24;
  localparam logic [7:0] LINEARITY_OFS   = 8'h32;
  localparam logic [7:0] AEQ_RESULT_OFS  = 8'h3b;

  localparam logic [7:0] LINK_FLAGS_RST  = 8'h41;
  localparam logic [7:0] LINEARITY_RST   = 8'h40;
  localparam logic [7:0] AEQ_RESULT_RST  = 8'h00;

  // Bit positions in link_state_flags.
  localparam int LONG_CH_BIT  = 7;
  localparam int DONE_BIT     = 6;
  localparam int HC_OVF_BIT   = 5;
  localparam int COMPL_BIT    = 3;
  localparam int WORK_BIT     = 2;
  localparam int LOWPWR_BIT   = 1;
  localparam int DETACH_BIT   = 0;

  // Field positions in output_linearity_control.
  localparam int BEACON_LSB   = 6;
  localparam int DISPLAY_LSB  = 4;
  localparam int DOWNSTR_LSB  = 2;
  localparam int UPSTR_LSB    = 0;

  // Field positions in adaptive_eq_result.
  localparam int DAC_DONE_BIT = 4;
  localparam int SETTING_LSB  = 0;

  localparam int HIT_CNT_W    = 13;
  localparam int SETTING_W    = 4;
  localparam int NUM_INPUTS   = 7;
  localparam int NUM_DOWNSTR  = 2;

  // Serial target address; value is a plain default.
  localparam logic [6:0] TARGET_ADDR = 7'h12;

  typedef enum logic [2:0] {
    SER_IDLE  = 3'b000,
    SER_ADDR  = 3'b001,
    SER_ACK_A = 3'b010,
    SER_WBYTE = 3'b011,
    SER_ACK_W = 3'b100,
    SER_RBYTE = 3'b101,
    SER_RACK  = 3'b110
  } ser_state_type;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic enter_working;
    logic enter_low_power;
    logic enter_detached;
    logic compliance;
  } link_event_type;

  typedef struct packed {
    logic                 running;
    logic                 long_detected;
    logic                 hit;
    logic                 dac_expired;
    logic [SETTING_W-1:0] full_result;
  } aeq_report_type;

  typedef struct packed {
    logic                 adaptive_equalizer_enable;
    logic                 adaptive_equalizer_variant;
    logic                 forced_search_enable;
    logic                 forced_search_trigger;
    logic                 upstream_limited_driver_enable;
    logic                 override_active;
    logic [SETTING_W-1:0] equalizer_override_value;
  } aeq_config_type;

endpackage

// File: hw/redriver_link_status_and_swing_regs.sv
// Purpose: Link status, equalizer result and output swing register bank.
// Assumes: Link and equalizer reports come from logic on core_clk.
// Notes:   Registers are reached only through the serial control port.
`timescale 1ns/1ps
module redriver_link_status_and_swing_regs (
  input  wire logic                                 core_clk,
  input  wire logic                                 srst,
  input  wire logic                                 scl_in,
  input  wire logic                                 sda_in,
  output logic                                      sda_o,
  output logic                                      sda_oe_n,
  input  redriver_regs_pkg::link_event_type         link_evt,
  input  redriver_regs_pkg::aeq_report_type         aeq_rpt,
  input  redriver_regs_pkg::aeq_config_type         aeq_cfg,
  input  wire logic [redriver_regs_pkg::NUM_INPUTS-1:0]
                    [redriver_regs_pkg::SETTING_W-1:0] eq_select,
  input  wire logic [redriver_regs_pkg::NUM_DOWNSTR-1:0]
                    [redriver_regs_pkg::SETTING_W-1:0] long_eq_select,
  output logic [redriver_regs_pkg::NUM_INPUTS-1:0]
               [redriver_regs_pkg::SETTING_W-1:0]    eq_applied,
  output logic [1:0]                                beacon_transmit_swing,
  output logic [1:0]                                display_path_swing,
  output logic [1:0]                                downstream_transmit_swing,
  output logic [1:0]                                upstream_transmit_swing,
  output logic [1:0]                                upstream_limited_swing
);

  localparam int SW = redriver_regs_pkg::SETTING_W;
  localparam int NI = redriver_regs_pkg::NUM_INPUTS;
  localparam int ND = redriver_regs_pkg::NUM_DOWNSTR;
  localparam int HW = redriver_regs_pkg::HIT_CNT_W;

  typedef struct packed {
    logic long_channel_selected_flag;
    logic equalizer_search_done_flag;
    logic hit_counter_overflow_flag;
    logic compliance_state_flag;
    logic link_working_state_flag;
    logic link_low_power_flag;
    logic link_detached_flag;
    logic [HW-1:0] hit_cnt;
    logic running_prev;
    logic dac_done_flag;
    logic [SW-1:0] chosen_equalizer_setting;
    logic [7:0] linearity;
    logic [1:0] beacon_lvl;
    logic [1:0] display_lvl;
    logic [1:0] downstr_lvl;
    logic [1:0] upstr_lvl;
    logic [1:0] upstr_limited_lvl;
    logic [NI-1:0][SW-1:0] applied;
  } bank_type;

  bank_type                       b_q;
  bank_type                       b_d;
  redriver_regs_pkg::reg_req_type req;
  logic [7:0]                     rdata;
  logic [7:0]                     flags_word;
  logic [7:0]                     result_word;
  logic                           fast_mode;
  logic                           search_start;
  logic                           done_valid;
  logic [NI-1:0][SW-1:0]          applied_d;

  serial_target u_serial (
    .core_clk (core_clk),
    .srst     (srst),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_o    (sda_o),
    .sda_oe_n (sda_oe_n),
    .req      (req),
    .rdata    (rdata)
  );

  assign fast_mode = aeq_cfg.adaptive_equalizer_enable
                   & ~aeq_cfg.adaptive_equalizer_variant;
  assign search_start = aeq_rpt.running & ~b_q.running_prev;
  assign done_valid =
      (b_q.link_working_state_flag & aeq_cfg.adaptive_equalizer_enable)
    | (aeq_cfg.forced_search_enable & ~aeq_cfg.forced_search_trigger);

  // The reserved bit of the status word reads as zero.
  always_comb begin
    flags_word = 8'h00;
    flags_word[redriver_regs_pkg::LONG_CH_BIT] =
      b_q.long_channel_selected_flag;
    flags_word[redriver_regs_pkg::DONE_BIT] = b_q.equalizer_search_done_flag;
    flags_word[redriver_regs_pkg::HC_OVF_BIT] = b_q.hit_counter_overflow_flag;
    flags_word[redriver_regs_pkg::COMPL_BIT] = b_q.compliance_state_flag;
    flags_word[redriver_regs_pkg::WORK_BIT] = b_q.link_working_state_flag;
    flags_word[redriver_regs_pkg::LOWPWR_BIT] = b_q.link_low_power_flag;
    flags_word[redriver_regs_pkg::DETACH_BIT] = b_q.link_detached_flag;
    result_word = 8'h00;
    result_word[redriver_regs_pkg::DAC_DONE_BIT] = b_q.dac_done_flag;
    result_word[redriver_regs_pkg::SETTING_LSB +: SW] =
      b_q.chosen_equalizer_setting;
  end

  // Read data follows the serial port pointer; unmapped offsets read zero.
  always_comb begin
    unique case (req.addr)
      redriver_regs_pkg::LINK_FLAGS_OFS: rdata = flags_word;
      redriver_regs_pkg::LINEARITY_OFS:  rdata = b_q.linearity;
      redriver_regs_pkg::AEQ_RESULT_OFS: rdata = result_word;
      default:                           rdata = 8'h00;
    endcase
  end

  // per-input settings
  // Each input carries its own four-bit choice of sixteen settings, except inputs 0 and 1, which share one setting under override or full search.
  for (genvar i = 0; i < NI; i++) begin : g_input
    always_comb begin
      applied_d[i] = eq_select[i];
      if (i < ND) begin
        if (aeq_cfg.override_active) begin
          applied_d[i] = aeq_cfg.equalizer_override_value;
        end else if (fast_mode) begin
          applied_d[i] = aeq_rpt.long_detected ?
                         long_eq_select[i] : eq_select[i];
        end else if (aeq_cfg.adaptive_equalizer_enable) begin
          applied_d[i] = b_q.chosen_equalizer_setting;
        end
      end
    end
  end

  always_comb begin
    b_d = b_q;
    b_d.running_prev = aeq_rpt.running;
    b_d.applied = applied_d;

    if (req.wr && req.addr == redriver_regs_pkg::LINEARITY_OFS) begin
      b_d.linearity = req.wdata;
    end

    if (!aeq_cfg.adaptive_equalizer_enable) begin
      b_d.long_channel_selected_flag = 1'b0;
    end else if (fast_mode) begin
      b_d.long_channel_selected_flag = aeq_rpt.long_detected;
    end

    if (done_valid) begin
      b_d.equalizer_search_done_flag = ~aeq_rpt.running;
    end

    if (search_start) begin
      b_d.hit_cnt = '0;
      b_d.hit_counter_overflow_flag = 1'b0;
    end
    if (aeq_rpt.hit) begin
      b_d.hit_cnt = b_d.hit_cnt + HW'(1);
      if (&b_d.hit_cnt == 1'b0 && &b_q.hit_cnt && !search_start) begin
        b_d.hit_counter_overflow_flag = 1'b1;
      end
    end

    b_d.compliance_state_flag = link_evt.compliance;

    if (link_evt.enter_working) begin
      b_d.link_working_state_flag = 1'b1;
      b_d.link_low_power_flag = 1'b0;
      b_d.link_detached_flag = 1'b0;
    end
    if (link_evt.enter_low_power) begin
      b_d.link_low_power_flag = 1'b1;
      b_d.link_working_state_flag = 1'b0;
      b_d.link_detached_flag = 1'b0;
    end
    if (link_evt.enter_detached) begin
      b_d.link_detached_flag = 1'b1;
      b_d.link_working_state_flag = 1'b0;
      b_d.link_low_power_flag = 1'b0;
    end

    if (search_start) begin
      b_d.dac_done_flag = 1'b0;
    end
    if (aeq_rpt.dac_expired) begin
      b_d.dac_done_flag = 1'b1;
    end

    if (aeq_cfg.override_active) begin
      b_d.chosen_equalizer_setting = aeq_cfg.equalizer_override_value;
    end else if (fast_mode) begin
      b_d.chosen_equalizer_setting = applied_d[0];
    end else if (aeq_cfg.adaptive_equalizer_enable
                 && b_q.running_prev && !aeq_rpt.running) begin
      b_d.chosen_equalizer_setting = aeq_rpt.full_result;
    end

    b_d.beacon_lvl =
      ~b_q.linearity[redriver_regs_pkg::BEACON_LSB +: 2];
    b_d.display_lvl =
      ~b_q.linearity[redriver_regs_pkg::DISPLAY_LSB +: 2];
    b_d.downstr_lvl =
      ~b_q.linearity[redriver_regs_pkg::DOWNSTR_LSB +: 2];
    if (aeq_cfg.upstream_limited_driver_enable) begin
      b_d.upstr_limited_lvl =
        ~b_q.linearity[redriver_regs_pkg::UPSTR_LSB +: 2];
    end else begin
      b_d.upstr_lvl = ~b_q.linearity[redriver_regs_pkg::UPSTR_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      b_q <= '0;
      b_q.long_channel_selected_flag <= redriver_regs_pkg::LINK_FLAGS_RST
        [redriver_regs_pkg::LONG_CH_BIT];
      b_q.equalizer_search_done_flag <= redriver_regs_pkg::LINK_FLAGS_RST
        [redriver_regs_pkg::DONE_BIT];
      b_q.link_detached_flag <= redriver_regs_pkg::LINK_FLAGS_RST
        [redriver_regs_pkg::DETACH_BIT];
      b_q.dac_done_flag <= redriver_regs_pkg::AEQ_RESULT_RST
        [redriver_regs_pkg::DAC_DONE_BIT];
      b_q.chosen_equalizer_setting <= redriver_regs_pkg::AEQ_RESULT_RST
        [redriver_regs_pkg::SETTING_LSB +: SW];
      b_q.linearity <= redriver_regs_pkg::LINEARITY_RST;
      b_q.beacon_lvl <=
        ~redriver_regs_pkg::LINEARITY_RST[redriver_regs_pkg::BEACON_LSB +: 2];
      b_q.display_lvl <= 2'h3;
      b_q.downstr_lvl <= 2'h3;
      b_q.upstr_lvl <= 2'h3;
      b_q.upstr_limited_lvl <= 2'h3;
    end else begin
      b_q <= b_d;
    end
  end

  assign eq_applied                = b_q.applied;
  assign beacon_transmit_swing     = b_q.beacon_lvl;
  assign display_path_swing        = b_q.display_lvl;
  assign downstream_transmit_swing = b_q.downstr_lvl;
  assign upstream_transmit_swing   = b_q.upstr_lvl;
  assign upstream_limited_swing    = b_q.upstr_limited_lvl;

endmodule // redriver_link_status_and_swing_regs

// File: hw/serial_target.sv
// Purpose: Serial control port target that moves bytes to a register bank.
// Assumes: Pins are asynchronous; the bank answers reads combinationally.
// Notes:   First written byte sets the pointer; pointer auto-increments.
`timescale 1ns/1ps
module serial_target (
  input  wire logic                            core_clk,
  input  wire logic                            srst,
  input  wire logic                            scl_in,
  input  wire logic                            sda_in,
  output logic                                 sda_o,
  output logic                                 sda_oe_n,
  output redriver_regs_pkg::reg_req_type       req,
  input  wire logic [7:0]                      rdata
);

  typedef struct packed {
    logic [2:0]                       scl_p;
    logic [2:0]                       sda_p;
    logic                             scl_f;
    logic                             sda_f;
    redriver_regs_pkg::ser_state_type st;
    logic [3:0]                       bitn;
    logic [7:0]                       sh;
    logic                             rw;
    logic                             ptr_next;
    logic [7:0]                       ptr;
    logic                             drv;
    redriver_regs_pkg::reg_req_type   req;
  } ser_type;

  ser_type s_q;
  ser_type s_d;
  logic    rise;
  logic    fall;
  logic    start;
  logic    stop;

  always_comb begin
    s_d = s_q;
    s_d.scl_p = {s_q.scl_p[1:0], scl_in};
    s_d.sda_p = {s_q.sda_p[1:0], sda_in};
    // A pin change counts once the second and third stages agree.
    if (s_q.scl_p[1] == s_q.scl_p[2]) begin
      s_d.scl_f = s_q.scl_p[2];
    end
    if (s_q.sda_p[1] == s_q.sda_p[2]) begin
      s_d.sda_f = s_q.sda_p[2];
    end
    rise  = s_d.scl_f & ~s_q.scl_f;
    fall  = ~s_d.scl_f & s_q.scl_f;
    start = s_q.scl_f & s_d.scl_f & s_q.sda_f & ~s_d.sda_f;
    stop  = s_q.scl_f & s_d.scl_f & ~s_q.sda_f & s_d.sda_f;
    s_d.req.wr = 1'b0;
    s_d.req.addr = s_q.ptr;
    if (start) begin
      s_d.st   = redriver_regs_pkg::SER_ADDR;
      s_d.bitn = 4'h0;
      s_d.drv  = 1'b0;
    end else if (stop) begin
      s_d.st  = redriver_regs_pkg::SER_IDLE;
      s_d.drv = 1'b0;
    end else if (rise) begin
      unique case (s_q.st)
        redriver_regs_pkg::SER_ADDR, redriver_regs_pkg::SER_WBYTE: begin
          s_d.sh   = {s_q.sh[6:0], s_d.sda_f};
          s_d.bitn = s_q.bitn + 4'h1;
        end
        redriver_regs_pkg::SER_RACK: begin
          if (s_d.sda_f) begin
            s_d.st = redriver_regs_pkg::SER_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      unique case (s_q.st)
        redriver_regs_pkg::SER_ADDR: begin
          if (s_q.bitn == 4'h8) begin
            if (s_q.sh[7:1] == redriver_regs_pkg::TARGET_ADDR) begin
              s_d.st  = redriver_regs_pkg::SER_ACK_A;
              s_d.rw  = s_q.sh[0];
              s_d.drv = 1'b1;
            end else begin
              s_d.st = redriver_regs_pkg::SER_IDLE;
            end
          end
        end
        redriver_regs_pkg::SER_ACK_A, redriver_regs_pkg::SER_RACK: begin
          if (s_q.st == redriver_regs_pkg::SER_ACK_A && !s_q.rw) begin
            s_d.st       = redriver_regs_pkg::SER_WBYTE;
            s_d.drv      = 1'b0;
            s_d.bitn     = 4'h0;
            s_d.ptr_next = 1'b1;
          end else begin
            s_d.st   = redriver_regs_pkg::SER_RBYTE;
            s_d.sh   = rdata;
            s_d.drv  = ~rdata[7];
            s_d.bitn = 4'h1;
            s_d.ptr  = s_q.ptr + 8'h01;
          end
        end
        redriver_regs_pkg::SER_WBYTE: begin
          if (s_q.bitn == 4'h8) begin
            s_d.st  = redriver_regs_pkg::SER_ACK_W;
            s_d.drv = 1'b1;
            if (s_q.ptr_next) begin
              s_d.ptr      = s_q.sh;
              s_d.ptr_next = 1'b0;
            end else begin
              s_d.req.wr    = 1'b1;
              s_d.req.wdata = s_q.sh;
              s_d.ptr       = s_q.ptr + 8'h01;
            end
          end
        end
        redriver_regs_pkg::SER_ACK_W: begin
          s_d.st   = redriver_regs_pkg::SER_WBYTE;
          s_d.drv  = 1'b0;
          s_d.bitn = 4'h0;
        end
        redriver_regs_pkg::SER_RBYTE: begin
          if (s_q.bitn == 4'h8) begin
            s_d.st  = redriver_regs_pkg::SER_RACK;
            s_d.drv = 1'b0;
          end else begin
            s_d.sh   = {s_q.sh[6:0], 1'b0};
            s_d.drv  = ~s_q.sh[6];
            s_d.bitn = s_q.bitn + 4'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q       <= '0;
      s_q.scl_p <= 3'h7;
      s_q.sda_p <= 3'h7;
      s_q.scl_f <= 1'b1;
      s_q.sda_f <= 1'b1;
      s_q.st    <= redriver_regs_pkg::SER_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = ~s_q.drv;
  assign req      = s_q.req;

endmodule // serial_target
